// ### rtl/iwdt_pkg.sv
package iwdt_pkg;
   // ==========================================================
   // Port addresses and keys
   localparam logic [7:0] IWDT_INDEX_PORT  = 8'h2e;
   localparam logic [7:0] IWDT_DATA_PORT   = 8'h2f;
   localparam logic [7:0] IWDT_KEY_UNLOCK  = 8'h87;
   localparam logic [7:0] IWDT_KEY_LOCK    = 8'haa;
   localparam logic [7:0] IWDT_GROUP_WDT   = 8'h08;
   localparam logic [7:0] IWDT_ACT_ON      = 8'h01;
   // ==========================================================
   // Register indices
   localparam logic [7:0] IWDT_IDX_DEVSEL  = 8'h07;
   localparam logic [7:0] IWDT_IDX_ACT     = 8'h30;
   localparam logic [7:0] IWDT_IDX_UNIT    = 8'hf5;
   localparam logic [7:0] IWDT_IDX_COUNT   = 8'hf6;
   localparam logic [7:0] IWDT_IDX_CTRL    = 8'hf7;
   // ==========================================================
   // Field positions
   localparam int IWDT_UNIT_BIT   = 3;
   localparam int IWDT_MOUSE_BIT  = 7;
   localparam int IWDT_KBD_BIT    = 6;
   localparam int IWDT_FORCE_BIT  = 5;
   localparam int IWDT_STAT_BIT   = 4;
   // ==========================================================
   // Reset values
   localparam logic [7:0] IWDT_COUNT_RST  = 8'h00;
   localparam logic [7:0] IWDT_UNIT_RST   = 8'h00;
   localparam logic [7:0] IWDT_DEVSEL_RST = 8'h00;
   // ==========================================================
   // Timing
   localparam longint IWDT_CLK_HZ       = 100000000;
   localparam longint IWDT_SEC_S        = 1;
   localparam longint IWDT_SEC_CYCLES   = IWDT_SEC_S * IWDT_CLK_HZ;
   localparam int     IWDT_SEC_PER_MIN  = 60;

   // Host I/O request carried as one bundle
   typedef struct packed {
      logic       wr;
      logic       rd;
      logic [7:0] addr;
      logic [7:0] wdata;
   } iwdt_io_s;

   typedef enum logic [1:0] {
      IWDT_LOCKED,
      IWDT_KEY1,
      IWDT_CONFIG
   } iwdt_cfg_e;
endpackage

// ### rtl/iwdt_tick.sv
`timescale 1ns/1ps
module iwdt_tick
   import iwdt_pkg::*;
#(
   parameter longint SEC_CYCLES = IWDT_SEC_CYCLES
) (
   input  wire logic core_clk,  // System clock
   input  wire logic sys_rst,   // Synchronous reset
   input  wire logic restart,   // Realign the prescaler
   input  wire logic minutes,   // 1 selects minute ticks
   output logic      tick       // One-cycle unit tick
);
   // ==========================================================
   // Prescaler
   // Elaboration check: the cycle counter is 32 bits and needs two states
   if (SEC_CYCLES < 2 || SEC_CYCLES > 64'd4294967295) begin : g_bad_cycles
      $error("iwdt_tick: SEC_CYCLES out of range");
   end

   logic [31:0] cyc_q;
   logic [5:0]  sec_q;
   logic        sec_end;
   logic        unit_end;

   assign sec_end  = (cyc_q == 32'(SEC_CYCLES - 1));
   assign unit_end = !minutes || (sec_q == 6'(IWDT_SEC_PER_MIN - 1));

   // Cycle counter; restart realigns so a fresh load gets a full unit
   always_ff @(posedge core_clk) begin
      if (sys_rst || restart || sec_end) begin
         cyc_q <= 32'h0;
      end else begin
         cyc_q <= cyc_q + 32'h1;
      end
   end

   // Seconds within a minute
   always_ff @(posedge core_clk) begin
      if (sys_rst || restart) begin
         sec_q <= 6'h0;
      end else if (sec_end) begin
         sec_q <= unit_end ? 6'h0 : sec_q + 6'h1;
      end
   end

   // Tick pulse, registered
   always_ff @(posedge core_clk) begin
      if (sys_rst || restart) begin
         tick <= 1'b0;
      end else begin
         tick <= sec_end && unit_end;
      end
   end
endmodule

// ### rtl/iwdt_top.sv
// What this block does
// - Registers reached by writing index to port 2E, data via port 2F.
// - Two successive 87 writes to index port enter configuration state.
// - Writing AA to index port leaves configuration state and relocks.
// - Writing 08 to index 07 selects the watchdog register group.
// - Writing 01 to index 30 enables the watchdog; disabled after reset.
// - Index F5 bit 3 selects unit: 0 seconds (default), 1 minutes.
// - Count register F6 at zero holds the timer stopped; resets zero.
// - Count 01 to FF sets timeout length; expiry asserts timeout output.
// - Every count register write restarts the countdown from that value.
// - F7 bit 7 set lets mouse activity restart the count; resets 0.
// - F7 bit 6 set lets keyboard activity restart the count; resets 0.
// - Writing 1 to F7 bit 5 forces timeout now while index 30 enables the watchdog, bit self-clears.
// - F7 bit 4 reads 1 once a timeout has occurred.
`timescale 1ns/1ps
module iwdt_top
   import iwdt_pkg::*;
#(
   parameter longint SEC_CYCLES = IWDT_SEC_CYCLES
) (
   input  wire logic       core_clk,   // 100 MHz clock
   input  wire logic       sys_rst,    // Synchronous reset, active high
   input  wire logic       io_wr,      // Host I/O write strobe
   input  wire logic       io_rd,      // Host I/O read strobe
   input  wire logic [7:0] io_addr,    // Host I/O port address
   input  wire logic [7:0] io_wdata,   // Host I/O write data
   input  wire logic       mouse_act,  // Mouse activity pin
   input  wire logic       kbd_act,    // Keyboard activity pin
   output logic [7:0]      io_rdata,   // Read data, valid cycle after io_rd
   output logic            io_rvalid,  // Read data valid pulse
   output logic            wdt_timeout // Interrupt or reset request
);
   // ==========================================================
   // Host request decode
   iwdt_io_s   req;
   iwdt_cfg_e  cfg_q;
   logic [7:0] index_q;
   logic [7:0] devsel_q;
   logic       active_q;
   logic [7:0] unit_q;
   logic [7:0] count_q;
   logic [7:0] remain_q;
   logic       mouse_en_q;
   logic       kbd_en_q;
   logic       status_q;
   logic       tick;
   logic       idx_wr;
   logic       dat_wr;
   logic       wdt_sel;
   logic       wr_count;
   logic       wr_ctrl;
   logic       force_to;
   logic       act_restart;
   logic       restart;
   logic       expire;
   logic [1:0] mouse_sync_q;
   logic [1:0] kbd_sync_q;
   logic       mouse_prev_q;
   logic       kbd_prev_q;

   assign req = '{wr: io_wr, rd: io_rd, addr: io_addr, wdata: io_wdata};

   function automatic logic is_wdt_reg(input logic [7:0] idx);
      is_wdt_reg = (idx == IWDT_IDX_UNIT) || (idx == IWDT_IDX_COUNT)
                || (idx == IWDT_IDX_CTRL) || (idx == IWDT_IDX_ACT);
   endfunction

   assign idx_wr   = req.wr && (req.addr == IWDT_INDEX_PORT);
   // Locked state drops every data-port write
   assign dat_wr   = req.wr && (req.addr == IWDT_DATA_PORT) && (cfg_q == IWDT_CONFIG);
   assign wdt_sel  = (devsel_q == IWDT_GROUP_WDT);
   assign wr_count = dat_wr && wdt_sel && (index_q == IWDT_IDX_COUNT);
   assign wr_ctrl  = dat_wr && wdt_sel && (index_q == IWDT_IDX_CTRL);
   assign force_to = wr_ctrl && req.wdata[IWDT_FORCE_BIT] && active_q;

   // ==========================================================
   // Key sequence state
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         cfg_q <= IWDT_LOCKED;
      end else if (idx_wr) begin
         case (cfg_q)
            IWDT_LOCKED: cfg_q <= (req.wdata == IWDT_KEY_UNLOCK) ? IWDT_KEY1 : IWDT_LOCKED;
            // Second key must follow directly, any other index write rearms
            IWDT_KEY1:   cfg_q <= (req.wdata == IWDT_KEY_UNLOCK) ? IWDT_CONFIG : IWDT_LOCKED;
            IWDT_CONFIG: cfg_q <= (req.wdata == IWDT_KEY_LOCK) ? IWDT_LOCKED : IWDT_CONFIG;
            default:     cfg_q <= IWDT_LOCKED;
         endcase
      end
   end

   // Index latch, only meaningful inside configuration state
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         index_q <= 8'h00;
      end else if (idx_wr && cfg_q == IWDT_CONFIG) begin
         index_q <= req.wdata;
      end
   end

   // ==========================================================
   // Configuration registers
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         devsel_q <= IWDT_DEVSEL_RST;
      end else if (dat_wr && index_q == IWDT_IDX_DEVSEL) begin
         devsel_q <= req.wdata;
      end
   end

   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         active_q <= 1'b0;
      end else if (dat_wr && wdt_sel && index_q == IWDT_IDX_ACT) begin
         active_q <= (req.wdata == IWDT_ACT_ON);
      end
   end

   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         unit_q <= IWDT_UNIT_RST;
      end else if (dat_wr && wdt_sel && index_q == IWDT_IDX_UNIT) begin
         unit_q <= req.wdata;
      end
   end

   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         count_q <= IWDT_COUNT_RST;
      end else if (wr_count) begin
         count_q <= req.wdata;
      end
   end

   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         mouse_en_q <= 1'b0;
         kbd_en_q   <= 1'b0;
      end else if (wr_ctrl) begin
         mouse_en_q <= req.wdata[IWDT_MOUSE_BIT];
         kbd_en_q   <= req.wdata[IWDT_KBD_BIT];
      end
   end

   // ==========================================================
   // Activity inputs: two flops, then edge detect on the second
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         mouse_sync_q <= 2'b00;
         kbd_sync_q   <= 2'b00;
         mouse_prev_q <= 1'b0;
         kbd_prev_q   <= 1'b0;
      end else begin
         mouse_sync_q <= {mouse_sync_q[0], mouse_act};
         kbd_sync_q   <= {kbd_sync_q[0], kbd_act};
         mouse_prev_q <= mouse_sync_q[1];
         kbd_prev_q   <= kbd_sync_q[1];
      end
   end

   assign act_restart = (mouse_en_q && mouse_sync_q[1] && !mouse_prev_q)
                     || (kbd_en_q && kbd_sync_q[1] && !kbd_prev_q);
   assign restart = wr_count || act_restart;

   // ==========================================================
   // Countdown
   iwdt_tick #(
      .SEC_CYCLES (SEC_CYCLES)
   ) u_tick (
      .core_clk (core_clk),
      .sys_rst  (sys_rst),
      .restart  (restart),
      .minutes  (unit_q[IWDT_UNIT_BIT]),
      .tick     (tick)
   );

   // Expire only from a running count of one on the last tick
   assign expire = active_q && tick && (remain_q == 8'h01) && !restart;

   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         remain_q <= IWDT_COUNT_RST;
      end else if (wr_count) begin
         remain_q <= req.wdata;
      end else if (act_restart) begin
         remain_q <= count_q;
      end else if (active_q && tick && remain_q != 8'h00) begin
         remain_q <= remain_q - 8'h01;
      end
      // Zero stays zero, so a stopped timer never wraps to a long count
   end

   // Timeout is sticky; a new count write or a restart clears it
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         wdt_timeout <= 1'b0;
      end else if (expire || force_to) begin
         wdt_timeout <= 1'b1;
      end else if (restart) begin
         wdt_timeout <= 1'b0;
      end
   end

   // Status set wins over the clear by a count write
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         status_q <= 1'b0;
      end else if (expire || force_to) begin
         status_q <= 1'b1;
      end else if (wr_count) begin
         status_q <= 1'b0;
      end
   end

   // ==========================================================
   // Read path, one cycle latency; force bit always reads 0
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         io_rdata  <= 8'h00;
         io_rvalid <= 1'b0;
      end else begin
         io_rvalid <= req.rd && (req.addr == IWDT_DATA_PORT || req.addr == IWDT_INDEX_PORT);
         // Reads of foreign ports get no valid, so their data must stay zero too
         if (!req.rd || cfg_q != IWDT_CONFIG
             || (req.addr != IWDT_DATA_PORT && req.addr != IWDT_INDEX_PORT)) begin
            io_rdata <= 8'h00;
         end else if (req.addr == IWDT_INDEX_PORT) begin
            io_rdata <= index_q;
         end else if (index_q == IWDT_IDX_DEVSEL) begin
            io_rdata <= devsel_q;
         end else if (!wdt_sel || !is_wdt_reg(index_q)) begin
            io_rdata <= 8'h00;
         end else if (index_q == IWDT_IDX_ACT) begin
            io_rdata <= {7'h00, active_q};
         end else if (index_q == IWDT_IDX_UNIT) begin
            io_rdata <= unit_q;
         end else if (index_q == IWDT_IDX_COUNT) begin
            io_rdata <= remain_q;
         end else begin
            io_rdata <= {mouse_en_q, kbd_en_q, 1'b0, status_q, 4'h0};
         end
      end
   end
endmodule

// ### test/iwdt_host.sv
`timescale 1ns/1ps
// ==========
// Host model: one-cycle strobes launched just after the edge
module iwdt_host
   import iwdt_pkg::*;
(
   input  wire logic       core_clk,  // Clock
   input  wire logic [7:0] io_rdata,  // Read data
   input  wire logic       io_rvalid, // Read valid
   output logic            io_wr,     // Write strobe
   output logic            io_rd,     // Read strobe
   output logic [7:0]      io_addr,   // Port address
   output logic [7:0]      io_wdata   // Write data
);
   // Idle bus, address parked off both ports
   initial begin
      io_wr = 1'b0;
      io_rd = 1'b0;
      io_addr = 8'h00;
      io_wdata = 8'h00;
   end
   // Port write; data inverted after release so nothing stale lingers
   task automatic wr(input logic [7:0] port, input logic [7:0] data);
      @(posedge core_clk);
      #1;
      io_addr = port;
      io_wdata = data;
      io_wr = 1'b1;
      @(posedge core_clk);
      #1;
      io_wr = 1'b0;
      io_wdata = ~data;
   endtask
   // Port read; a missing valid yields unknown data
   task automatic rd(input logic [7:0] port, output logic [7:0] d);
      @(posedge core_clk);
      #1;
      io_addr = port;
      io_rd = 1'b1;
      @(posedge core_clk);
      #1;
      io_rd = 1'b0;
      d = io_rvalid ? io_rdata : 8'hxx;
   endtask
endmodule

// ### test/iwdt_checker.sv
`timescale 1ns/1ps
// ==========
// Port-level checks
module iwdt_checker
   import iwdt_pkg::*;
#(
   parameter longint SEC_CYCLES = IWDT_SEC_CYCLES
) (
   input wire logic       core_clk,   // Clock
   input wire logic       sys_rst,    // Reset
   input wire logic       io_wr,      // Write
   input wire logic       io_rd,      // Read
   input wire logic [7:0] io_addr,    // Address
   input wire logic [7:0] io_wdata,   // Data in
   input wire logic       mouse_act,  // Mouse
   input wire logic       kbd_act,    // Keyboard
   input wire logic [7:0] io_rdata,   // Data out
   input wire logic       io_rvalid,  // Valid
   input wire logic       wdt_timeout // Timeout
);
   logic [3:0] act_gap_q;
   logic       seen_wr_q;
   default clocking @(posedge core_clk); endclocking
   default disable iff (sys_rst);
   // Age of activity; restarts lag through the synchroniser
   always_ff @(posedge core_clk) begin
      if (sys_rst || mouse_act || kbd_act) act_gap_q <= 4'h0;
      else if (act_gap_q != 4'hf) act_gap_q <= act_gap_q + 4'h1;
   end
   // Any host write since reset
   always_ff @(posedge core_clk) begin
      if (sys_rst) seen_wr_q <= 1'b0;
      else if (io_wr) seen_wr_q <= 1'b1;
   end
   sequence port_rd;
      io_rd && (io_addr == IWDT_INDEX_PORT || io_addr == IWDT_DATA_PORT);
   endsequence
   rd_answer_a: assert property (port_rd |=> io_rvalid) else $error("read unanswered");
   rvalid_cause_a: assert property (io_rvalid |-> $past(io_rd)) else $error("stray valid");
   rvalid_pulse_a: assert property (io_rvalid && !io_rd |=> !io_rvalid) else $error("long");
   rdata_idle_a: assert property (!io_rvalid |-> io_rdata == 8'h00) else $error("rdata");
   reset_clear_a: assert property ($past(sys_rst) |-> !wdt_timeout && !io_rvalid)
      else $error("reset state");
   no_spur_a: assert property ($rose(wdt_timeout) |-> seen_wr_q) else $error("spurious");
   timeout_hold_a: assert property (wdt_timeout && !io_wr && act_gap_q > 4'h6 |=>
      wdt_timeout) else $error("timeout dropped");
   read_keeps_a: assert property ((port_rd and wdt_timeout) |=> wdt_timeout)
      else $error("read cleared");
endmodule
bind iwdt_top iwdt_checker #(.SEC_CYCLES(SEC_CYCLES)) i_chk (.core_clk(core_clk),
   .sys_rst(sys_rst), .io_wr(io_wr), .io_rd(io_rd), .io_addr(io_addr), .io_wdata(io_wdata),
   .mouse_act(mouse_act), .kbd_act(kbd_act), .io_rdata(io_rdata), .io_rvalid(io_rvalid),
   .wdt_timeout(wdt_timeout));

// ### test/iwdt_tb_top.sv
`timescale 1ns/1ps
// ==========
// Bench top; tick shortened to 10 cycles so minute runs stay brief
module iwdt_tb_top
   import iwdt_pkg::*;
;
   logic       core_clk, sys_rst, io_wr, io_rd, mouse_act, kbd_act, io_rvalid, wdt_timeout;
   logic [7:0] io_addr, io_wdata, io_rdata, d;
   int         error_cnt = 0;
   int         checks = 0;
   iwdt_host i_host (.core_clk(core_clk), .io_rdata(io_rdata), .io_rvalid(io_rvalid),
      .io_wr(io_wr), .io_rd(io_rd), .io_addr(io_addr), .io_wdata(io_wdata));
   iwdt_top #(.SEC_CYCLES(10)) i_dut (.core_clk(core_clk), .sys_rst(sys_rst), .io_wr(io_wr),
      .io_rd(io_rd), .io_addr(io_addr), .io_wdata(io_wdata), .mouse_act(mouse_act),
      .kbd_act(kbd_act), .io_rdata(io_rdata), .io_rvalid(io_rvalid), .wdt_timeout(wdt_timeout));
   // ==========
   // Helpers
   task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
      checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge core_clk);
      #1;
   endtask
   task automatic wreg(input logic [7:0] idx, input logic [7:0] val);
      i_host.wr(IWDT_INDEX_PORT, idx);
      i_host.wr(IWDT_DATA_PORT, val);
   endtask
   task automatic rreg(input logic [7:0] idx, input logic [7:0] exp);
      i_host.wr(IWDT_INDEX_PORT, idx);
      i_host.rd(IWDT_DATA_PORT, d);
      cmp(d, exp);
   endtask
   task automatic unlock();
      i_host.wr(IWDT_INDEX_PORT, IWDT_KEY_UNLOCK);
      i_host.wr(IWDT_INDEX_PORT, IWDT_KEY_UNLOCK);
   endtask
   task automatic give_verdict();
      $display("Checks %0d, mismatches %0d", checks, error_cnt);
      if (error_cnt == 0 && checks > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   // ==========
   // Scenarios
   task automatic t_reset();
      wreg(IWDT_IDX_COUNT, 8'h05);
      unlock();
      wreg(IWDT_IDX_ACT, 8'h01);
      wreg(IWDT_IDX_DEVSEL, IWDT_GROUP_WDT);
      rreg(IWDT_IDX_ACT, 8'h00);
      rreg(IWDT_IDX_COUNT, 8'h00);
      rreg(IWDT_IDX_CTRL, 8'h00);
      wreg(IWDT_IDX_ACT, 8'h01);
      rreg(IWDT_IDX_ACT, 8'h01);
      $display("Test reset done, mismatches %0d", error_cnt);
   endtask
   task automatic t_count();
      wreg(IWDT_IDX_COUNT, 8'h02);
      cyc(17);
      cmp({7'h00, wdt_timeout}, 8'h00);
      cyc(8);
      cmp({7'h00, wdt_timeout}, 8'h01);
      rreg(IWDT_IDX_CTRL, 8'h10);
      wreg(IWDT_IDX_COUNT, 8'h03);
      cmp({7'h00, wdt_timeout}, 8'h00);
      cyc(20);
      wreg(IWDT_IDX_COUNT, 8'h03);
      cyc(25);
      cmp({7'h00, wdt_timeout}, 8'h00);
      wreg(IWDT_IDX_COUNT, 8'h00);
      cyc(60);
      cmp({7'h00, wdt_timeout}, 8'h00);
      wreg(IWDT_IDX_UNIT, 8'h08);
      wreg(IWDT_IDX_COUNT, 8'h01);
      cyc(590);
      cmp({7'h00, wdt_timeout}, 8'h00);
      cyc(15);
      cmp({7'h00, wdt_timeout}, 8'h01);
      wreg(IWDT_IDX_UNIT, 8'h00);
      $display("Test count done, mismatches %0d", error_cnt);
   endtask
   // Enabled activity pulse mid-count pushes expiry past the unrestarted point;
   // the third pass pulses both pins with both sources disabled, so no restart
   task automatic t_activity();
      for (int i = 0; i < 3; i++) begin
         wreg(IWDT_IDX_CTRL, (i == 0) ? 8'h80 : (i == 1) ? 8'h40 : 8'h00);
         wreg(IWDT_IDX_COUNT, 8'h02);
         cyc(12);
         if (i != 1) mouse_act = 1'b1;
         if (i != 0) kbd_act = 1'b1;
         cyc(1);
         mouse_act = 1'b0;
         kbd_act = 1'b0;
         cyc(11);
         cmp({7'h00, wdt_timeout}, (i == 2) ? 8'h01 : 8'h00);
         cyc(30);
         rreg(IWDT_IDX_CTRL, (i == 0) ? 8'h90 : (i == 1) ? 8'h50 : 8'h10);
      end
      $display("Test activity done, mismatches %0d", error_cnt);
   endtask
   task automatic t_force_lock();
      wreg(IWDT_IDX_CTRL, 8'h00);
      wreg(IWDT_IDX_COUNT, 8'h00);
      wreg(IWDT_IDX_CTRL, 8'h20);
      cyc(2);
      cmp({7'h00, wdt_timeout}, 8'h01);
      rreg(IWDT_IDX_CTRL, 8'h10);
      i_host.rd(IWDT_INDEX_PORT, d);
      cmp(d, IWDT_IDX_CTRL);
      i_host.wr(IWDT_INDEX_PORT, IWDT_KEY_LOCK);
      wreg(IWDT_IDX_COUNT, 8'h05);
      cmp({7'h00, wdt_timeout}, 8'h01);
      i_host.rd(IWDT_DATA_PORT, d);
      cmp(d, 8'h00);
      unlock();
      rreg(IWDT_IDX_COUNT, 8'h00);
      $display("Test force and lock done, mismatches %0d", error_cnt);
   endtask
   // ==========
   // Clock, reset, sequence and watchdog
   initial begin
      core_clk = 1'b0;
      forever #5 core_clk = ~core_clk;
   end
   initial begin
      sys_rst = 1'b1;
      mouse_act = 1'b0;
      kbd_act = 1'b0;
      cyc(4);
      sys_rst = 1'b0;
      t_reset();
      t_count();
      t_activity();
      t_force_lock();
      give_verdict();
   end
   // Whole run needs about 1050 cycles
   initial begin
      #60000;
      error_cnt++;
      give_verdict();
   end
endmodule
